// File: bench/dma_flags_chk.sv
// port assertions for the dma event flag block
module dma_flags_chk (
	// clock and reset
	input wire logic                      core_clk,
	input wire logic                      srst,
	// apb
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [7:0]                paddr,
	input wire logic [31:0]               pwdata,
	input wire logic [31:0]               prdata,
	input wire logic                      pready,
	input wire logic                      pslverr,
	// engine side
	input wire dma_flags_pkg::dmaEvents_t events,
	input wire logic                      txSuspended,
	input wire logic                      rxSuspended,
	input wire logic                      txPollDemand,
	input wire logic                      rxPollDemand,
	input wire dma_flags_pkg::descWrites_t descWrites
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	logic pollWr;
	assign pollWr = psel && penable && pready && pwrite
		&& paddr == dma_flags_pkg::POLL_ADDR;
	chk_tx_desc_mark: assert property (events.txDone |=>
		descWrites.txDesc1DoneSet) else $error("tx done mark missing");
	chk_under_suspend: assert property (events.txUnderflow |=>
		descWrites.txDesc0UnderSet && txSuspended) else $error("underflow");
	chk_rx_status: assert property (events.rxDone |=>
		descWrites.rxDescStatusSet) else $error("rx status write missing");
	chk_tx_unav: assert property (events.txFetch &&
		events.txFetchHostOwned |=> txSuspended) else $error("tx suspend");
	chk_rx_unav: assert property (events.rxFetch &&
		events.rxFetchHostOwned |=> rxSuspended) else $error("rx suspend");
	chk_rx_poll: assert property (pollWr && pwdata[1] |=>
		rxPollDemand ##1 !rxSuspended) else $error("rx poll resume");
	chk_rx_frame: assert property (rxSuspended &&
		events.rxFrameArrive |-> ##[1:2] !rxSuspended) else $error("rx frame");
	chk_tx_poll: assert property (pollWr && pwdata[0] |=>
		txPollDemand ##1 !txSuspended) else $error("tx poll resume");
	chk_unmapped_zero: assert property (pslverr |->
		pready && prdata == 32'h0000_0000) else $error("unmapped access");
	cover property (events.txUnderflow ##1 txSuspended);
	cover property (rxPollDemand);
	cover property (pslverr);
endmodule
bind dma_status_event_flags dma_flags_chk dma_flags_chk_inst (.*);

// File: bench/dma_status_event_flags_test.sv
// self-checking bench for the dma event flag block
module dma_status_event_flags_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] FL = dma_flags_pkg::FLAGS_ADDR;
	localparam logic [7:0] MK = dma_flags_pkg::MASK_ADDR;
	localparam logic [7:0] PL = dma_flags_pkg::POLL_ADDR;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, irq;
	logic txSuspended, rxSuspended, txPollDemand, rxPollDemand;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	dma_flags_pkg::dmaEvents_t events = '0;
	dma_flags_pkg::descWrites_t descWrites;
	int fails = 0;
	int checksDone = 0;
	always #12.5 core_clk = ~core_clk;
	dma_status_event_flags dma_status_event_flags_inst (.core_clk, .srst,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .events, .txSuspended, .rxSuspended, .txPollDemand,
		.rxPollDemand, .descWrites, .irq);
	host_apb_model host (.core_clk, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task giveVerdict;
		$display("mismatches %0d of %0d checks", fails, checksDone);
		if (fails == 0 && checksDone > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task fire(input dma_flags_pkg::dmaEvents_t e);
		@(posedge core_clk);
		events <= e;
		@(posedge core_clk);
		events <= '0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rd);
	endtask
	task flags(input logic [15:0] e);
		host.xfer(1'b0, FL, 32'h0000_0000, rd);
		chk({16'h0000, rd[15:0]}, {16'h0000, e});
	endtask
	task settle;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		#400000;
		fails++;
		giveVerdict();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		flags(16'h0000);
		host.xfer(1'b0, MK, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		fire('{txStart:'1, default:'0});
		fire('{txEarlyDone:'1, default:'0});
		flags(16'h0400);
		fire('{txDone:'1, default:'0});
		flags(16'h0001);
		wr(FL, 32'h0000_0000);
		flags(16'h0001);
		wr(FL, 32'hFFFF_FFFF);
		flags(16'h0000);
		fire('{rxEarlyDone:'1, default:'0});
		flags(16'h4000);
		fire('{rxDone:'1, default:'0});
		flags(16'h0040);
		wr(FL, 32'h0000_FFFF);
		fire('{txUnderflow:'1, default:'0});
		flags(16'h0020);
		chk(rd & 32'h0070_0000, 32'h0060_0000);
		wr(PL, 32'h0000_0001);
		settle();
		chk({31'h0, txSuspended}, 32'h0);
		wr(FL, 32'h0000_FFFF);
		fire('{txFetch:'1, txFetchHostOwned:'1, default:'0});
		flags(16'h0004);
		chk(rd & 32'h0070_0000, 32'h0060_0000);
		wr(FL, 32'h0000_FFFF);
		fire('{rxFetch:'1, rxFetchHostOwned:'1, default:'0});
		flags(16'h0080);
		chk({31'h0, rxSuspended}, 32'h1);
		wr(FL, 32'h0000_FFFF);
		fire('{rxFetch:'1, rxFetchHostOwned:'1, default:'0});
		flags(16'h0000);
		wr(PL, 32'h0000_0002);
		settle();
		chk({31'h0, rxSuspended}, 32'h0);
		fire('{rxFetch:'1, default:'0});
		fire('{rxFetch:'1, rxFetchHostOwned:'1, default:'0});
		flags(16'h0080);
		fire('{rxFrameArrive:'1, default:'0});
		settle();
		chk({31'h0, rxSuspended}, 32'h0);
		wr(FL, 32'h0000_FFFF);
		fire('{txStopEnter:'1, default:'0});
		fire('{rxStopEnter:'1, default:'0});
		flags(16'h0102);
		chk({31'h0, irq}, 32'h0);
		wr(MK, 32'h0000_0100);
		flags(16'h8102);
		chk({31'h0, irq}, 32'h1);
		wr(FL, 32'h0000_FFFF);
		flags(16'h0000);
		chk({31'h0, irq}, 32'h0);
		fire('{rxFrameStart:'1, default:'0});
		repeat (2048) fire('{rxByteValid:'1, default:'0});
		flags(16'h0000);
		fire('{rxByteValid:'1, default:'0});
		flags(16'h0200);
		host.xfer(1'b0, 8'h30, 32'h0000_0000, rd);
		chk({31'h0, host.err}, 32'h1);
		chk(rd, 32'h0000_0000);
		giveVerdict();
	end
endmodule

// File: bench/host_apb_model.sv
// apb master model standing in for host software
module host_apb_model (
	// clock
	input  wire logic        core_clk,
	// apb master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic err;
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		err = 1'b0;
	end
	// one transfer; request held until pready is seen at an edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// File: include/dma_flags_pkg.sv
// constants and carriers for the dma event flag block
package dma_flags_pkg;

	// ---------------------------------------------------------------
	// register byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] FLAGS_ADDR = 8'h14;
	localparam logic [7:0] MASK_ADDR  = 8'h20;
	localparam logic [7:0] POLL_ADDR  = 8'h24;

	// ---------------------------------------------------------------
	// status field positions
	// ---------------------------------------------------------------
	localparam int TX_DONE_BIT   = 0;
	localparam int TX_STOP_BIT   = 1;
	localparam int TX_UNAV_BIT   = 2;
	localparam int TX_UNDER_BIT  = 5;
	localparam int RX_DONE_BIT   = 6;
	localparam int RX_UNAV_BIT   = 7;
	localparam int RX_STOP_BIT   = 8;
	localparam int RX_OVER_BIT   = 9;
	localparam int TX_EARLY_BIT  = 10;
	localparam int RX_EARLY_BIT  = 14;
	localparam int ABN_SUM_BIT   = 15;
	localparam int TX_STATE_LSB  = 20;
	localparam int POLL_TX_BIT   = 0;
	localparam int POLL_RX_BIT   = 1;

	// implemented sticky flags and the abnormal group
	localparam logic [15:0] FLAG_BITS  = 16'h47E7;
	localparam logic [15:0] ABN_BITS   = 16'h05A2;
	localparam logic [15:0] FLAGS_RST  = 16'h0000;
	localparam logic [15:0] MASK_RST   = 16'h0000;

	// transmit state field codes
	localparam logic [2:0] TXS_STOPPED = 3'h0;
	localparam logic [2:0] TXS_RUNNING = 3'h1;
	localparam logic [2:0] TXS_SUSPEND = 3'h6;

	// overlength limit, inside the 2048 to 2560 byte window
	localparam logic [11:0] RX_OVER_LIMIT = 12'h800;

	// ---------------------------------------------------------------
	// event pulses from the descriptor dma engines
	// ---------------------------------------------------------------
	typedef struct packed {
		logic txDone;
		logic txEarlyDone;
		logic txUnderflow;
		logic txFetch;
		logic txFetchHostOwned;
		logic txStopEnter;
		logic txStart;
		logic rxDone;
		logic rxEarlyDone;
		logic rxFetch;
		logic rxFetchHostOwned;
		logic rxStopEnter;
		logic rxFrameArrive;
		logic rxFrameStart;
		logic rxByteValid;
	} dmaEvents_t;

	// descriptor write requests back to the engines
	typedef struct packed {
		logic txDesc0UnderSet;
		logic txDesc1DoneSet;
		logic rxDescStatusSet;
	} descWrites_t;

endpackage

// File: rtl/dma_status_event_flags.sv
// dma status event flags with apb register access
//
// Decided for this implementation: the register offsets and the APB slave port.
module dma_status_event_flags (
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      srst,
	// apb slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// dma engine events
	input  wire dma_flags_pkg::dmaEvents_t events,
	// process control back to the engines
	output logic                           txSuspended,
	output logic                           rxSuspended,
	output logic                           txPollDemand,
	output logic                           rxPollDemand,
	output dma_flags_pkg::descWrites_t     descWrites,
	// interrupt
	output logic                           irq
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [15:0]  flags_r;
	logic [15:0]  flags_nxt;
	logic [15:0]  mask_r;
	logic [15:0]  mask_nxt;
	logic [31:0]  prdata_r;
	logic [31:0]  prdata_nxt;
	logic         pready_r;
	logic         pready_nxt;
	logic         pslverr_r;
	logic         pslverr_nxt;
	logic         txSusp_r;
	logic         txSusp_nxt;
	logic         txStopped_r;
	logic         txStopped_nxt;
	logic         rxSusp_r;
	logic         rxSusp_nxt;
	logic         rxPrevDma_r;
	logic         rxPrevDma_nxt;
	logic [11:0]  rxCount_r;
	logic [11:0]  rxCount_nxt;
	logic         rxOverSeen_r;
	logic         rxOverSeen_nxt;
	logic         txPoll_r;
	logic         txPoll_nxt;
	logic         rxPoll_r;
	logic         rxPoll_nxt;
	logic         irq_r;
	logic         irq_nxt;
	dma_flags_pkg::descWrites_t descWr_r;
	dma_flags_pkg::descWrites_t descWr_nxt;

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	logic         access;
	logic         wrDone;
	logic         hitFlags;
	logic         hitMask;
	logic         hitPoll;
	logic         mapped;
	logic [15:0]  setVec;
	logic [15:0]  clrVec;
	logic [15:0]  w1c;
	logic [2:0]   txState;
	logic         abnSum;
	logic         rxOver;
	logic [31:0]  readWord;

	// a transfer completes where the answer is sampled high
	always_comb begin
		access   = psel & penable;
		wrDone   = access & pready_r & pwrite;
		hitFlags = 1'b0;
		hitMask  = 1'b0;
		hitPoll  = 1'b0;
		if (paddr == dma_flags_pkg::FLAGS_ADDR) begin
			hitFlags = 1'b1;
		end else if (paddr == dma_flags_pkg::MASK_ADDR) begin
			hitMask = 1'b1;
		end else if (paddr == dma_flags_pkg::POLL_ADDR) begin
			hitPoll = 1'b1;
		end
		mapped = hitFlags | hitMask | hitPoll;
	end

	// ---------------------------------------------------------------
	// event flags
	// ---------------------------------------------------------------
	always_comb begin
		// overlength: the byte past the limit of one frame
		rxOver = events.rxByteValid & ~rxOverSeen_r &
		         (rxCount_r == dma_flags_pkg::RX_OVER_LIMIT);
		setVec = 16'h0000;
		setVec[dma_flags_pkg::TX_DONE_BIT]  = events.txDone;
		setVec[dma_flags_pkg::TX_STOP_BIT]  = events.txStopEnter;
		setVec[dma_flags_pkg::TX_UNAV_BIT]  =
			events.txFetch & events.txFetchHostOwned;
		setVec[dma_flags_pkg::TX_UNDER_BIT] = events.txUnderflow;
		setVec[dma_flags_pkg::RX_DONE_BIT]  = events.rxDone;
		setVec[dma_flags_pkg::RX_UNAV_BIT]  =
			events.rxFetch & events.rxFetchHostOwned &
			rxPrevDma_r;
		setVec[dma_flags_pkg::RX_STOP_BIT]  = events.rxStopEnter;
		setVec[dma_flags_pkg::RX_OVER_BIT]  = rxOver;
		setVec[dma_flags_pkg::TX_EARLY_BIT] = events.txEarlyDone;
		setVec[dma_flags_pkg::RX_EARLY_BIT] = events.rxEarlyDone;
		// completion clears the matching early flag
		clrVec = 16'h0000;
		clrVec[dma_flags_pkg::TX_EARLY_BIT] = events.txDone;
		clrVec[dma_flags_pkg::RX_EARLY_BIT] = events.rxDone;
		// only a completed write to the flag word clears
		w1c = (wrDone & hitFlags) ? pwdata[15:0] : 16'h0000;
		// a set in the clearing cycle wins
		flags_nxt = ((flags_r & ~w1c & ~clrVec) | setVec) &
		            dma_flags_pkg::FLAG_BITS;
		// mask bits exist only where a flag exists
		mask_nxt = mask_r;
		if (wrDone & hitMask) begin
			mask_nxt = pwdata[15:0] & dma_flags_pkg::FLAG_BITS;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			flags_r <= dma_flags_pkg::FLAGS_RST;
			mask_r  <= dma_flags_pkg::MASK_RST;
		end else begin
			flags_r <= flags_nxt;
			mask_r  <= mask_nxt;
		end
	end

	// ---------------------------------------------------------------
	// process suspend and stop tracking
	// ---------------------------------------------------------------
	always_comb begin
		txPoll_nxt = wrDone & hitPoll & pwdata[dma_flags_pkg::POLL_TX_BIT];
		rxPoll_nxt = wrDone & hitPoll & pwdata[dma_flags_pkg::POLL_RX_BIT];
		txSusp_nxt = txSusp_r;
		// resume needs a poll demand or a txStart event
		if (txPoll_r | events.txStart) begin
			txSusp_nxt = 1'b0;
		end
		if (events.txUnderflow |
		    (events.txFetch & events.txFetchHostOwned)) begin
			txSusp_nxt = 1'b1;
		end
		// a stop overrides any pending suspend
		if (events.txStopEnter) begin
			txSusp_nxt = 1'b0;
		end
		txStopped_nxt = txStopped_r;
		if (events.txStart) begin
			txStopped_nxt = 1'b0;
		end
		if (events.txStopEnter) begin
			txStopped_nxt = 1'b1;
		end
		rxSusp_nxt = rxSusp_r;
		if (rxPoll_r | events.rxFrameArrive) begin
			rxSusp_nxt = 1'b0;
		end
		if (events.rxFetch & events.rxFetchHostOwned) begin
			rxSusp_nxt = 1'b1;
		end
		if (events.rxStopEnter) begin
			rxSusp_nxt = 1'b0;
		end
		// remembers who owned the last fetched descriptor
		rxPrevDma_nxt = rxPrevDma_r;
		if (events.rxFetch) begin
			rxPrevDma_nxt = ~events.rxFetchHostOwned;
		end
		// counting stops once the frame has been flagged
		rxCount_nxt    = rxCount_r;
		rxOverSeen_nxt = rxOverSeen_r | rxOver;
		if (events.rxFrameStart) begin
			rxCount_nxt    = 12'h000;
			rxOverSeen_nxt = 1'b0;
		end else if (events.rxByteValid & ~rxOverSeen_r &
		             ~rxOver) begin
			rxCount_nxt = rxCount_r + 12'h001;
		end
		descWr_nxt.txDesc0UnderSet = events.txUnderflow;
		descWr_nxt.txDesc1DoneSet  = events.txDone;
		descWr_nxt.rxDescStatusSet = events.rxDone;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			txSusp_r     <= 1'b0;
			txStopped_r  <= 1'b1;
			rxSusp_r     <= 1'b0;
			// reset counts as a dma-owned fetch
			rxPrevDma_r  <= 1'b1;
			rxCount_r    <= 12'h000;
			rxOverSeen_r <= 1'b0;
			txPoll_r     <= 1'b0;
			rxPoll_r     <= 1'b0;
			descWr_r     <= '0;
		end else begin
			txSusp_r     <= txSusp_nxt;
			txStopped_r  <= txStopped_nxt;
			rxSusp_r     <= rxSusp_nxt;
			rxPrevDma_r  <= rxPrevDma_nxt;
			rxCount_r    <= rxCount_nxt;
			rxOverSeen_r <= rxOverSeen_nxt;
			txPoll_r     <= txPoll_nxt;
			rxPoll_r     <= rxPoll_nxt;
			descWr_r     <= descWr_nxt;
		end
	end

	// ---------------------------------------------------------------
	// read data, answer and interrupt
	// ---------------------------------------------------------------
	always_comb begin
		// stopped outranks suspended in the state field
		if (txStopped_r) begin
			txState = dma_flags_pkg::TXS_STOPPED;
		end else if (txSusp_r) begin
			txState = dma_flags_pkg::TXS_SUSPEND;
		end else begin
			txState = dma_flags_pkg::TXS_RUNNING;
		end
		// summary is derived, so a w1c write cannot clear it
		abnSum = |(flags_r & mask_r & dma_flags_pkg::ABN_BITS);
		readWord = 32'h0000_0000;
		if (hitFlags) begin
			readWord[15:0] = flags_r;
			readWord[dma_flags_pkg::ABN_SUM_BIT] = abnSum;
			readWord[dma_flags_pkg::TX_STATE_LSB +: 3] = txState;
		end else if (hitMask) begin
			readWord[15:0] = mask_r;
		end
		// one wait state: ready in the second access cycle
		pready_nxt  = access & ~pready_r;
		// unmapped offsets answer with an error and read zero
		pslverr_nxt = access & ~pready_r & ~mapped;
		prdata_nxt  = prdata_r;
		if (access & ~pready_r) begin
			prdata_nxt = pwrite ? 32'h0000_0000 : readWord;
		end
		// irq tracks the flags as they register
		irq_nxt = |(flags_nxt & mask_nxt);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			irq_r     <= 1'b0;
		end else begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq_r     <= irq_nxt;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign prdata       = prdata_r;
	assign pready       = pready_r;
	assign pslverr      = pslverr_r;
	assign txSuspended  = txSusp_r;
	assign rxSuspended  = rxSusp_r;
	assign txPollDemand = txPoll_r;
	assign rxPollDemand = rxPoll_r;
	assign descWrites   = descWr_r;
	assign irq          = irq_r;

endmodule
